//--- rtl/frc_pkg.sv
/*
  Package for the fixed reference control block: register layout, reset values,
  gain and mode encodings, and the carrier structs shared by the top design file and the bench.
  Assumes a single clock domain running at 250 MHz.
*/
`default_nettype none
package frc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] FRC_ADDR_CTRL     = 4'h0;  // Reference control register.
  localparam logic [7:0] FRC_CTRL_RESET    = 8'h00;
  localparam int         FRC_BIT_ENABLE    = 7;
  localparam int         FRC_BIT_READY     = 6;
  localparam int         FRC_BIT_TS_EN     = 5;
  localparam int         FRC_BIT_TS_RNG    = 4;
  localparam logic [7:0] FRC_WRITE_MASK    = 8'hB3;  // Bits 6, 3 and 2 are not writable.

  // ****************************************************************
  // Field encodings
  // ****************************************************************
  localparam logic [1:0] FRC_GAIN_OFF      = 2'h0;
  localparam logic [1:0] FRC_GAIN_X1       = 2'h1;
  localparam logic [1:0] FRC_GAIN_X2       = 2'h2;
  localparam logic [1:0] FRC_GAIN_X4       = 2'h3;
  localparam logic [2:0] FRC_OSC_INTERNAL  = 3'h2;
  localparam logic [2:0] FRC_FREQ_MATCH    = 3'h0;  // Upper three bits of the frequency field.
  localparam logic [1:0] FRC_BOR_SOFTWARE  = 2'h1;
  localparam logic [1:0] FRC_BOR_NO_SLEEP  = 2'h2;
  localparam logic [1:0] FRC_BOR_ALWAYS    = 2'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int         FRC_CLK_MHZ       = 250;
  localparam int         FRC_SETTLE_US     = 25;  // Stabilization time in microseconds.
  localparam int         FRC_SETTLE_CYC    = FRC_SETTLE_US * FRC_CLK_MHZ;
  localparam logic [3:0] FRC_SETTLE_RST    = 4'h0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [2:0] osc_select;
    logic [3:0] freq_select;
    logic [1:0] bor_mode;
    logic       bor_fast;
    logic       reg_power_mode;
    logic       sleeping;
  } frc_sys_t;

  typedef struct packed {
    logic       buf_on;
    logic       gain_x1;
    logic       gain_x2;
    logic       gain_x4;
  } frc_gain_t;

endpackage
`default_nettype wire

//--- rtl/frc_settle.sv
/*
  Stabilization timer: counts clock cycles after the effective enable rises
  and raises a ready level once the count expires.
  Assumes the enable input is synchronous to the clock.
*/
`default_nettype none
module frc_settle #(
  parameter int CYCLES = frc_pkg::FRC_SETTLE_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_enable,
  output logic      o_ready
);
  import frc_pkg::*;

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] count_q;

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Counting restarts whenever the enable drops, so each rise waits the full time.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_q <= '0;
      o_ready <= 1'b0;
    end else if (!i_enable) begin
      count_q <= '0;
      o_ready <= 1'b0;
    end else if (count_q == W'(CYCLES - 1)) begin
      o_ready <= 1'b1;
    end else begin
      count_q <= count_q + W'(1);
    end
  end

  // Ready rises only where enable was already high two edges earlier.
  a_ready_needs_wait: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_ready) |-> $past(i_enable, 2)) else $error("ready rose without enable");

endmodule // frc_settle
`default_nettype wire

//--- rtl/frc_top.sv
/*
  Fixed reference control: one 8-bit control register on a plain strobe port,
  effective enable from software and system conditions, buffer gain decode and
  the ready flag after stabilization, or held set in the full-voltage variant.
  Assumes system condition inputs arrive asynchronously and are synchronised here.
*/
// Implementation choices: the address map and the strobed register port.
`default_nettype none
module frc_top #(
  parameter int SETTLE_CYCLES = frc_pkg::FRC_SETTLE_CYC,
  parameter bit HIGH_VOLTAGE  = 1'b0
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  input  wire logic [3:0]        I_ADDR,
  input  wire logic [7:0]        I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  input  wire frc_pkg::frc_sys_t I_SYS,
  output logic [7:0]             O_RDATA,
  output logic                   O_REF_ON,
  output logic                   O_REF_READY,
  output frc_pkg::frc_gain_t     O_GAIN,
  output logic                   O_TS_EN,
  output logic                   O_TS_RANGE
);
  import frc_pkg::*;

  logic [7:0] ctrl_q;
  frc_sys_t   sys_meta_q;
  frc_sys_t   sys_q;
  logic       need_d;
  logic       settle_ready;
  logic       ready_flag;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Decodes the two-bit gain field into buffer enable and one-hot gain.
  function automatic frc_gain_t gain_decode(input logic [1:0] code);
    frc_gain_t g;
    g.buf_on  = (code != FRC_GAIN_OFF);
    g.gain_x1 = (code == FRC_GAIN_X1);
    g.gain_x2 = (code == FRC_GAIN_X2);
    g.gain_x4 = (code == FRC_GAIN_X4);
    return g;
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // System conditions come from other logic and pass two flip-flops.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sys_meta_q <= '0;
      sys_q      <= '0;
    end else begin
      sys_meta_q <= I_SYS;
      sys_q      <= sys_meta_q;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Only writable bits store; the ready bit and bits 3..2 ignore writes.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_q <= FRC_CTRL_RESET;
    end else if (I_WR && I_ADDR == FRC_ADDR_CTRL) begin
      ctrl_q <= I_WDATA & FRC_WRITE_MASK;
    end
  end

  // ****************************************************************
  // Reference request
  // ****************************************************************
  // Software enable ORed with every system condition that needs the reference.
  always_comb begin
    need_d = ctrl_q[FRC_BIT_ENABLE];
    if (sys_q.osc_select == FRC_OSC_INTERNAL && sys_q.freq_select[3:1] == FRC_FREQ_MATCH
        && !sys_q.sleeping) begin
      need_d = 1'b1;
    end
    if (sys_q.bor_mode == FRC_BOR_ALWAYS) begin
      need_d = 1'b1;
    end
    if (sys_q.bor_mode == FRC_BOR_NO_SLEEP && sys_q.bor_fast) begin
      need_d = 1'b1;
    end
    if (sys_q.bor_mode == FRC_BOR_SOFTWARE && sys_q.bor_fast) begin
      need_d = 1'b1;
    end
    if (HIGH_VOLTAGE && sys_q.reg_power_mode && !sys_q.sleeping) begin
      need_d = 1'b1;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Reference and buffer drive come straight from flip-flops. Software is
  // expected to clear the gain when off; the buffer still follows the field.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_REF_ON   <= 1'b0;
      O_GAIN     <= '0;
      O_TS_EN    <= 1'b0;
      O_TS_RANGE <= 1'b0;
    end else begin
      O_REF_ON   <= need_d;
      O_GAIN     <= gain_decode(ctrl_q[1:0]);
      O_TS_EN    <= ctrl_q[FRC_BIT_TS_EN];
      O_TS_RANGE <= ctrl_q[FRC_BIT_TS_RNG];
    end
  end

  // Stabilization timer runs from the registered effective enable.
  frc_settle #(
    .CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .i_clk    (I_CLK),
    .i_rst    (I_RST),
    .i_enable (O_REF_ON),
    .o_ready  (settle_ready)
  );

  assign ready_flag = HIGH_VOLTAGE ? 1'b1 : (settle_ready & O_REF_ON);

  // Ready output and read data are registered.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_REF_READY <= 1'b0;
      O_RDATA     <= 8'h00;
    end else begin
      O_REF_READY <= ready_flag;
      if (I_RD && I_ADDR == FRC_ADDR_CTRL) begin
        O_RDATA <= {ctrl_q[7], ready_flag, ctrl_q[5:4], 2'h0, ctrl_q[1:0]};
      end else begin
        O_RDATA <= 8'h00;  // Unmapped or idle reads return zero.
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Every output is a flip-flop loaded from the state sampled at one edge, so each
  // consequent looks one edge past its cause; a register write needs one edge more.

  // Setting the enable bit turns the reference on once the register has taken it.
  a_enable_turns_on: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_WR && I_ADDR == FRC_ADDR_CTRL && I_WDATA[7]) |-> ##2 O_REF_ON) else $error("enable ignored");

  // With no request of any kind the reference stays off.
  a_off_when_idle: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!need_d) |=> !O_REF_ON) else $error("reference on without request");

  // Each nonzero gain code drives the buffer enable and its own gain line; the 1x and 2x checks also want the other lines low.
  a_gain_decode: assert property (@(posedge I_CLK) disable iff (I_RST)
    (ctrl_q[1:0] == FRC_GAIN_X4) |=> (O_GAIN.gain_x4 && O_GAIN.buf_on)) else $error("gain 4x decode");

  a_gain_x2_decode: assert property (@(posedge I_CLK) disable iff (I_RST)
    (ctrl_q[1:0] == FRC_GAIN_X2) |=> (O_GAIN.buf_on && O_GAIN.gain_x2 && !O_GAIN.gain_x1 && !O_GAIN.gain_x4))
    else $error("gain 2x decode");

  a_gain_x1_decode: assert property (@(posedge I_CLK) disable iff (I_RST)
    (ctrl_q[1:0] == FRC_GAIN_X1) |=> (O_GAIN.buf_on && O_GAIN.gain_x1 && !O_GAIN.gain_x2 && !O_GAIN.gain_x4))
    else $error("gain 1x decode");

  // Code zero switches the whole buffer off.
  a_gain_off: assert property (@(posedge I_CLK) disable iff (I_RST)
    (ctrl_q[1:0] == FRC_GAIN_OFF) |=> (O_GAIN == '0)) else $error("buffer not off");

  // Brown-out settings that need the reference keep it on.
  a_bor_request: assert property (@(posedge I_CLK) disable iff (I_RST)
    (sys_q.bor_mode == FRC_BOR_ALWAYS) |=> O_REF_ON) else $error("brownout request lost");

  a_bor_no_sleep: assert property (@(posedge I_CLK) disable iff (I_RST)
    (sys_q.bor_mode == FRC_BOR_NO_SLEEP && sys_q.bor_fast) |=> O_REF_ON) else $error("no-sleep bor lost");

  a_bor_soft: assert property (@(posedge I_CLK) disable iff (I_RST)
    (sys_q.bor_mode == FRC_BOR_SOFTWARE && sys_q.bor_fast) |=> O_REF_ON) else $error("soft bor lost");

  // The fast internal oscillator needs the reference only while the device is awake.
  a_osc_request: assert property (@(posedge I_CLK) disable iff (I_RST)
    (sys_q.osc_select == FRC_OSC_INTERNAL && sys_q.freq_select[3:1] == FRC_FREQ_MATCH && !sys_q.sleeping)
    |=> O_REF_ON) else $error("oscillator request lost");

  a_osc_sleeping: assert property (@(posedge I_CLK) disable iff (I_RST)
    (sys_q.osc_select == FRC_OSC_INTERNAL && sys_q.sleeping && !ctrl_q[FRC_BIT_ENABLE]
     && sys_q.bor_mode == 2'h0) |=> !O_REF_ON) else $error("oscillator request in sleep");

  // The regulator needs the reference in the full-voltage variant while awake.
  a_regulator_request: assert property (@(posedge I_CLK) disable iff (I_RST)
    (HIGH_VOLTAGE && sys_q.reg_power_mode && !sys_q.sleeping) |=> O_REF_ON)
    else $error("regulator request lost");

  // In the low-voltage variant ready stays low while the reference is off and on the edge after it turns on.
  a_ready_low_off: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!HIGH_VOLTAGE && !O_REF_ON) |=> !O_REF_READY) else $error("ready while off");

  a_ready_restart: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!HIGH_VOLTAGE && $rose(O_REF_ON)) |=> !O_REF_READY) else $error("ready without a fresh wait");

  a_read_not_ready: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!HIGH_VOLTAGE && I_RD && I_ADDR == FRC_ADDR_CTRL && !O_REF_ON) |=> !O_RDATA[FRC_BIT_READY])
    else $error("ready bit read while off");

  // The ready bit is read-only and the unused bits never store.
  a_write_masked: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_WR && I_ADDR == FRC_ADDR_CTRL) |=> (ctrl_q[3:2] == 2'h0 && !ctrl_q[FRC_BIT_READY]))
    else $error("read-only bits stored");

  // The full-voltage variant shows ready from the first edge after reset. The sampled
  // reset keeps the release edge itself, where the flag is still clear, out of the check.
  a_ready_const: assert property (@(posedge I_CLK) disable iff (I_RST)
    (HIGH_VOLTAGE && !I_RST) |=> O_REF_READY) else $error("ready not forced");

  a_read_ready_hv: assert property (@(posedge I_CLK) disable iff (I_RST)
    (HIGH_VOLTAGE && I_RD && I_ADDR == FRC_ADDR_CTRL) |=> O_RDATA[FRC_BIT_READY])
    else $error("ready bit not forced");

endmodule // frc_top
`default_nettype wire

//--- test/frc_tb.sv
/*
  Self-checking bench for the fixed reference control block: register access, gain decode,
  effective enable from system conditions, ready timing, and both device variants.
  Assumes the package and the design files are compiled first and that assertions live in them.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import frc_pkg::*;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam int SETTLE = 8;
  logic       clk;
  logic       rst;
  logic       wr;
  logic       rd;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  frc_sys_t   sys;
  frc_gain_t  gain;
  logic       ref_on;
  logic       ready;
  logic       ts_en;
  logic       ts_rng;
  logic       hv_on;
  logic       hv_ready;
  int         n_mismatch;
  int         checks_done;
  int         n;
  // Expected {buf_on, x1, x2, x4} for gain codes 0 to 3.
  logic [3:0] gtab [4] = '{4'h0, 4'hC, 4'hA, 4'h9};
  // System inputs, then expected enable of the low- and high-voltage variants.
  logic [13:0] stab [12] = '{{3'h2, 4'h1, 5'h00, 2'h3}, {3'h2, 4'h2, 5'h00, 2'h0}, {3'h3, 4'h0, 5'h00, 2'h0},
    {3'h0, 4'h0, 5'h18, 2'h3}, {3'h0, 4'h0, 5'h14, 2'h3}, {3'h0, 4'h0, 5'h10, 2'h0}, {3'h0, 4'h0, 5'h0C, 2'h3},
    {3'h0, 4'h0, 5'h08, 2'h0}, {3'h0, 4'h0, 5'h04, 2'h0}, {3'h0, 4'h0, 5'h02, 2'h1}, {3'h0, 4'h0, 5'h03, 2'h0},
    {3'h2, 4'h0, 5'h01, 2'h0}};

  frc_top #(.SETTLE_CYCLES(SETTLE), .HIGH_VOLTAGE(1'b0)) dut_u (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_SYS(sys), .O_RDATA(rdata), .O_REF_ON(ref_on),
    .O_REF_READY(ready), .O_GAIN(gain), .O_TS_EN(ts_en), .O_TS_RANGE(ts_rng));
  frc_top #(.SETTLE_CYCLES(SETTLE), .HIGH_VOLTAGE(1'b1)) hv_u (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_SYS(sys), .O_RDATA(), .O_REF_ON(hv_on),
    .O_REF_READY(hv_ready), .O_GAIN(), .O_TS_EN(), .O_TS_RANGE());

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // The read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  // Counts cycles until the ready flag rises, bounded so a stuck flag cannot hang the run.
  task automatic wait_ready(output int c);
    c = 0;
    while (ready !== 1'b1 && c < 40) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // The tests need under two hundred cycles; far beyond that the run is taken as hung.
  initial begin
    #(20000 * 4);
    n_mismatch++;
    final_report();
  end

  // Runs the tests in order, each ending with one summary line.
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00; sys = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    check({ref_on, ready, gain, ts_en, ts_rng}, 8'h00);
    check({7'h0, hv_ready}, 8'h01);
    reg_read(FRC_ADDR_CTRL, FRC_CTRL_RESET);
    $display("test reset finished");
    reg_write(FRC_ADDR_CTRL, 8'hFF);
    reg_read(FRC_ADDR_CTRL, 8'hB3);
    check({5'h0, ref_on, ts_en, ts_rng}, 8'h07);
    wait_ready(n);
    check({7'h0, (n >= SETTLE && n <= SETTLE + 4)}, 8'h01);
    reg_read(FRC_ADDR_CTRL, 8'hF3);
    $display("test enable and ready finished");
    for (int g = 0; g < 4; g++) begin
      reg_write(FRC_ADDR_CTRL, 8'h80 | 8'(g));
      idle(2);
      check({4'h0, gain}, {4'h0, gtab[g]});
    end
    $display("test gain decode finished");
    reg_write(FRC_ADDR_CTRL, 8'h00);
    idle(3);
    check({6'h0, ref_on, ready}, 8'h00);
    reg_write(FRC_ADDR_CTRL, 8'h80);
    idle(4);
    reg_write(FRC_ADDR_CTRL, 8'h00);
    idle(3);
    reg_write(FRC_ADDR_CTRL, 8'h80);
    wait_ready(n);
    check({7'h0, (n >= SETTLE && n <= SETTLE + 4)}, 8'h01);
    reg_write(FRC_ADDR_CTRL, 8'h00);
    reg_write(4'h5, 8'hFF);
    reg_read(4'h5, 8'h00);
    reg_read(FRC_ADDR_CTRL, 8'h00);
    $display("test disable, restart and unmapped finished");
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      sys <= frc_sys_t'(stab[i][13:2]);
      idle(5);
      check({6'h0, ref_on, hv_on}, {6'h0, stab[i][1:0]});
    end
    @(posedge clk);
    sys <= frc_sys_t'({3'h0, 4'h0, 5'h18});
    idle(4);
    wait_ready(n);
    check({7'h0, ready}, 8'h01);
    check({7'h0, hv_ready}, 8'h01);
    $display("test system conditions finished");
    final_report();
  end
endmodule // tb
`default_nettype wire
